// ---- lmp_pkg.sv ----
/*
 * constants, field positions and types for the character display host port.
 * assumes a single clock domain (mclk) at CLK_PERIOD_NS.
 */
`default_nettype none

package lmp_pkg;

	// core clock and timing base
	localparam int CLK_PERIOD_NS   = 100;
	// internal resistor-timed oscillator period, plain default
	localparam int OSC_PERIOD_NS   = 4000;
	// mclk cycles per internal oscillator period (rounded down, at least 1)
	localparam int OSC_DIV         = (OSC_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
		OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int OSC_CNT_W       = 8;
	// oscillator ticks that one instruction keeps the busy flag set
	localparam logic [3:0] CMD_BUSY_TICKS = 4'h4;
	// RAM drain takes one oscillator tick per byte

	// data path widths and FIFO depth
	localparam int BYTE_W          = 8;
	localparam int ADDR_W          = 7;
	localparam int RAM_AW          = 8;
	localparam int FIFO_DEPTH      = 16;

	// glyph RAM uses six address bits
	localparam logic [6:0] GLYPH_MASK = 7'h3F;

	// command and status byte field positions
	localparam int CMD_TEXT_BIT    = 7;
	localparam int CMD_GLYPH_BIT   = 6;
	localparam int CMD_FUNC_BIT    = 5;
	localparam int CMD_WIDTH_BIT   = 4;
	localparam int CMD_ENTRY_BIT   = 2;
	localparam int CMD_INCR_BIT    = 1;
	localparam int STATUS_BUSY_BIT = 7;

	// reset values
	localparam logic RST_WIDTH8    = 1'b1;
	localparam logic RST_INCR      = 1'b1;

	// RAM prefetch engine
	typedef enum logic [1:0] {
		ENG_IDLE,
		ENG_FETCH,
		ENG_LOAD
	} lmp_eng_type;

endpackage : lmp_pkg

`default_nettype wire

// ---- lmp_fifo.sv ----
/*
 * byte FIFO between the host write side and the RAM drain.
 * assumes both sides in the mclk domain; clkEn freezes it.
 */
`default_nettype none

module lmp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             clkEn,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];  // entry storage
	logic [AW-1:0]    wrPtr_q;        // next write slot
	logic [AW-1:0]    rdPtr_q;        // oldest entry
	logic [AW:0]      count_q;        // entries held
	logic             push;           // accepted write
	logic             pop;            // accepted read

	// honest flags straight from the count
	assign inReady  = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outData  = store[rdPtr_q];

	// storage write, no reset needed for data
	always_ff @(posedge mclk) begin
		if (clkEn && push) begin
			store[wrPtr_q] <= inData;
		end
	end

	// pointers and count
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (clkEn) begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule // lmp_fifo

`default_nettype wire

// ---- lmp_ram.sv ----
/*
 * text and glyph RAM in one array; the top address bit picks glyph RAM.
 * assumes one access per cycle; read data follows one cycle after re.
 */
`default_nettype none

module lmp_ram
	import lmp_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              clkEn,
	input  wire logic              we,
	input  wire logic              re,
	input  wire logic [RAM_AW-1:0] addr,
	input  wire logic [BYTE_W-1:0] wdata,
	output logic      [BYTE_W-1:0] rdata
);
	logic [BYTE_W-1:0] mem [2**RAM_AW];  // both RAMs

	// synchronous write and registered read
	always_ff @(posedge mclk) begin
		if (clkEn) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			if (re) begin
				rdata <= mem[addr];
			end
		end
	end

endmodule // lmp_ram

`default_nettype wire

// ---- lmp_host_port.sv ----
/*
 * host parallel port of a character display controller: strobed
 * register access, 4/8-bit bus width, busy/address status, data
 * register with RAM auto transfer and address stepping.
 * assumes host pins already synchronous to mclk; the host polls busy.
 *
// Functional notes
// (R1) select high means data, low command
// (R2) direction high reads, low writes
// (R3) transfers happen only under the strobe
// (R4) low lines used only in 8-bit width
// (R5) upper lines carry both nibbles in 4-bit
// (R6) busy shows on the top data line
// (R7) bus width follows the width command bit
// (R8) two byte holding registers: data, command
// (R9) data register targets last addressed RAM
// (R10) data read reloads next RAM location
// (R11) data write is copied into RAM
// (R12) command register is write only
// (R13) select works the same in both widths
// (R14) external clock pin may replace oscillator
// (R15) busy blocks new instructions; host polls it
// (R16) status read returns address counter plus busy
// (R17) address counter steps after every RAM access
// (R18) data write lands in data register first
// (R19) 4-bit bytes go high nibble first
// (R20) capture on strobe fall, drive while high
 */
`default_nettype none

module lmp_host_port
	import lmp_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              clkEn,
	input  wire logic              oscExtSel,
	input  wire logic              clockInPin,
	input  wire logic              registerSelectPin,
	input  wire logic              readNotWrite,
	input  wire logic              strobe,
	input  wire logic [BYTE_W-1:0] hostDataIn,
	output logic      [BYTE_W-1:0] hostDataOut,
	output logic      [BYTE_W-1:0] hostDataOe,
	output logic                   busyFlag,
	output logic                   busWidth8
);
	logic              strobe_q;      // strobe one cycle ago
	logic              strobeFall;    // falling edge of strobe
	logic              clkPin_q;      // external clock last sample
	logic [OSC_CNT_W-1:0] oscCnt_q;   // internal oscillator divider
	logic              oscTick;       // one internal clock period
	logic              tick;          // selected timing tick
	logic              width8_q;      // bus width bit
	logic              incr_q;        // address step direction
	logic              glyphSel_q;    // RAM target
	logic [ADDR_W-1:0] addrCnt_q;     // address counter
	logic [ADDR_W-1:0] addrNext;      // counter after one step
	logic [BYTE_W-1:0] dataReg_q;     // data transfer register
	logic [BYTE_W-1:0] cmdReg_q;      // command register
	logic [3:0]        busyCnt_q;     // instruction busy ticks left
	logic              nibbleLow_q;   // next nibble is the low one
	logic [3:0]        nibHi_q;       // held high nibble on write
	logic              byteDone;      // a whole byte access ends
	logic [BYTE_W-1:0] wrByte;        // assembled write byte
	logic [BYTE_W-1:0] rdByte;        // byte the host is reading
	logic [BYTE_W-1:0] dataOut_q;     // registered bus drive value
	logic              cmdAccept;     // command write taken
	logic              dataWrite;     // data write completed
	logic              dataRead;      // data read completed
	logic              fifoInReady;   // FIFO has room
	logic              fifoOutValid;  // byte waiting for RAM
	logic [BYTE_W-1:0] fifoOutData;   // byte at FIFO head
	logic              drain;         // write FIFO head into RAM
	logic              ramRe;         // RAM read strobe
	logic [BYTE_W-1:0] ramRdata;      // RAM read data
	logic [RAM_AW-1:0] ramAddr;       // RAM address
	logic              fetchReq_q;    // prefetch requested
	lmp_eng_type       eng_q;         // prefetch engine state

	// strobe edge detect; inputs are synchronous already
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			strobe_q <= 1'b0;
			clkPin_q <= 1'b0;
		end else if (clkEn) begin
			strobe_q <= strobe;
			clkPin_q <= clockInPin;
		end
	end

	// (R20) capture on fall
	assign strobeFall = strobe_q && !strobe;

	// internal oscillator divider, free running
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			oscCnt_q <= '0;
		end else if (clkEn) begin
			if (oscCnt_q == OSC_CNT_W'(OSC_DIV - 1)) begin
				oscCnt_q <= '0;
			end else begin
				oscCnt_q <= oscCnt_q + 1'b1;
			end
		end
	end

	assign oscTick = (oscCnt_q == OSC_CNT_W'(OSC_DIV - 1));

	// (R14) external clock option
	// a rising edge on the clock pin replaces the divider tick
	assign tick = oscExtSel ? (clockInPin && !clkPin_q) : oscTick;

	// (R19) byte completes on second nibble
	// in 8-bit width every strobed access is a whole byte
	assign byteDone = strobeFall && (width8_q || nibbleLow_q);

	// (R5) nibbles on upper lines
	// (R4) low lines ignored when narrow
	assign wrByte = width8_q ? hostDataIn : {nibHi_q, hostDataIn[7:4]};

	// nibble phase tracking
	// (R13) same select in both widths
	// (R3) only strobed accesses count
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			nibbleLow_q <= 1'b0;
			nibHi_q     <= 4'h0;
		end else if (clkEn) begin
			if (cmdAccept && wrByte[CMD_FUNC_BIT] &&
					wrByte[7:6] == 2'b00) begin
				// width change restarts the nibble pairing
				nibbleLow_q <= 1'b0;
			end else if (strobeFall && !width8_q) begin
				// (R19) high nibble first
				nibbleLow_q <= !nibbleLow_q;
				if (!nibbleLow_q) begin
					nibHi_q <= hostDataIn[7:4];
				end
			end
		end
	end

	// (R15) no instruction while busy
	// (R1) select low, (R2) direction low
	assign cmdAccept = byteDone && !registerSelectPin && !readNotWrite &&
		!busyFlag;
	// (R1) select high: data register
	assign dataWrite = byteDone && registerSelectPin && !readNotWrite;
	assign dataRead  = byteDone && registerSelectPin && readNotWrite;

	// (R15) busy while operating
	// queued RAM writes count as internal work too
	assign busyFlag = (busyCnt_q != 4'h0) || fifoOutValid ||
		(eng_q != ENG_IDLE) || fetchReq_q;

	// instruction busy timer in oscillator ticks
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busyCnt_q <= 4'h0;
		end else if (clkEn) begin
			if (cmdAccept) begin
				busyCnt_q <= CMD_BUSY_TICKS;
			end else if (tick && busyCnt_q != 4'h0) begin
				busyCnt_q <= busyCnt_q - 1'b1;
			end
		end
	end

	// (R8) command holding register
	// (R12) written only, never read back
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmdReg_q <= '0;
		end else if (clkEn && cmdAccept) begin
			cmdReg_q <= wrByte;
		end
	end

	// command decode: width, entry direction
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			width8_q <= RST_WIDTH8;
			incr_q   <= RST_INCR;
		end else if (clkEn && cmdAccept) begin
			if (wrByte[7:5] == 3'b001) begin
				// (R7) width bit sets bus width
				width8_q <= wrByte[CMD_WIDTH_BIT];
			end else if (wrByte[7:2] == 6'b000001) begin
				incr_q <= wrByte[CMD_INCR_BIT];
			end
		end
	end

	assign busWidth8 = width8_q;

	// counter after one step, wrapped to the active RAM
	always_comb begin
		addrNext = incr_q ? addrCnt_q + 1'b1 : addrCnt_q - 1'b1;
		if (glyphSel_q) begin
			addrNext = addrNext & GLYPH_MASK;
		end
	end

	// address counter and RAM target
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			addrCnt_q  <= '0;
			glyphSel_q <= 1'b0;
		end else if (clkEn) begin
			if (cmdAccept && wrByte[CMD_TEXT_BIT]) begin
				// (R9) text address set selects text RAM
				addrCnt_q  <= wrByte[6:0];
				glyphSel_q <= 1'b0;
			end else if (cmdAccept && wrByte[7:6] == 2'b01) begin
				// (R9) glyph address set selects glyph RAM
				addrCnt_q  <= wrByte[6:0] & GLYPH_MASK;
				glyphSel_q <= 1'b1;
			end else if (drain || dataRead) begin
				// (R17) step after each access
				addrCnt_q <= addrNext;
			end
		end
	end

	// (R18) data write queues via FIFO
	// a full FIFO refuses the byte; busy already warns the host
	lmp_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk     (mclk),
		.rst      (rst),
		.clkEn    (clkEn),
		.inValid  (dataWrite),
		.inReady  (fifoInReady),
		.inData   (wrByte),
		.outValid (fifoOutValid),
		.outReady (drain),
		.outData  (fifoOutData)
	);

	// (R11) copy into RAM
	// one byte per tick; prefetch reads have the port first
	assign drain = fifoOutValid && tick && eng_q == ENG_IDLE && !fetchReq_q;

	// prefetch request after address set or data read
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fetchReq_q <= 1'b0;
		end else if (clkEn) begin
			if (cmdAccept && (wrByte[7] || wrByte[7:6] == 2'b01)) begin
				fetchReq_q <= 1'b1;
			end else if (dataRead) begin
				// (R10) reload after read
				fetchReq_q <= 1'b1;
			end else if (eng_q == ENG_IDLE && !fifoOutValid) begin
				fetchReq_q <= 1'b0;
			end
		end
	end

	// prefetch engine: address, wait for data, load register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			eng_q <= ENG_IDLE;
		end else if (clkEn) begin
			case (eng_q)
				ENG_IDLE: begin
					// pending writes land first so reads see them
					if (fetchReq_q && !fifoOutValid) begin
						eng_q <= ENG_FETCH;
					end
				end
				ENG_FETCH: begin
					eng_q <= ENG_LOAD;
				end
				ENG_LOAD: begin
					eng_q <= ENG_IDLE;
				end
				default: begin
					eng_q <= ENG_IDLE;
				end
			endcase
		end
	end

	assign ramRe   = (eng_q == ENG_FETCH);
	assign ramAddr = {glyphSel_q, addrCnt_q};

	lmp_ram u_ram (
		.mclk  (mclk),
		.clkEn (clkEn),
		.we    (drain),
		.re    (ramRe),
		.addr  (ramAddr),
		.wdata (fifoOutData),
		.rdata (ramRdata)
	);

	// (R8) data holding register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dataReg_q <= '0;
		end else if (clkEn) begin
			if (eng_q == ENG_LOAD) begin
				// (R10) next location loaded
				dataReg_q <= ramRdata;
			end else if (dataWrite && fifoInReady) begin
				// (R18) host byte held
				dataReg_q <= wrByte;
			end
		end
	end

	// byte offered to the host
	// (R16) status: counter plus busy
	// (R6) busy on top line
	// (R12) command code never returned
	always_comb begin
		if (registerSelectPin) begin
			rdByte = dataReg_q;
		end else begin
			rdByte = {1'b0, addrCnt_q};
			rdByte[STATUS_BUSY_BIT] = busyFlag;
		end
	end

	// registered drive value; narrow width picks the nibble
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dataOut_q <= '0;
		end else if (clkEn) begin
			if (width8_q) begin
				dataOut_q <= rdByte;
			end else if (nibbleLow_q) begin
				// (R5) low nibble on upper lines
				dataOut_q <= {rdByte[3:0], 4'h0};
			end else begin
				dataOut_q <= {rdByte[7:4], 4'h0};
			end
		end
	end

	assign hostDataOut = dataOut_q;

	// (R20) drive only while high
	// (R4) lower lines left undriven in 4-bit width
	assign hostDataOe = (strobe && strobe_q && readNotWrite) ?
		(width8_q ? 8'hFF : 8'hF0) : 8'h00;

endmodule // lmp_host_port

`default_nettype wire

// ---- lmp_port_props.sv ----
/* assertions on the host port pins: strobe, enables, busy and width.
   assumes binding to lmp_host_port with clkEn held high. */
`default_nettype none
module lmp_port_props
	import lmp_pkg::*;
(
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic              clkEn,
	input wire logic              oscExtSel,
	input wire logic              clockInPin,
	input wire logic              registerSelectPin,
	input wire logic              readNotWrite,
	input wire logic              strobe,
	input wire logic [BYTE_W-1:0] hostDataIn,
	input wire logic [BYTE_W-1:0] hostDataOut,
	input wire logic [BYTE_W-1:0] hostDataOe,
	input wire logic              busyFlag,
	input wire logic              busWidth8
);
	logic stbQ;  // strobe seen at the last edge
	logic lowHalf;  // next 4-bit strobe carries the low nibble
	wire logic take = stbQ && !strobe;  // falling strobe: transfer taken
	// a 4-bit byte only ends on its second nibble, so only then can work start
	wire logic byteEnd = take && (busWidth8 || lowHalf);
	wire logic sr = !registerSelectPin && readNotWrite;  // status read selected
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// strobe history, same reset as the port
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stbQ    <= 1'b0;
			lowHalf <= 1'b0;
		end else begin
			stbQ    <= strobe;
			// every taken strobe in 4-bit width flips the nibble phase
			lowHalf <= busWidth8 ? 1'b0 : (lowHalf ^ take);
		end
	end
	oe_strobe_a: assert property (hostDataOe != 8'h00 |-> strobe && stbQ && readNotWrite)
		else $error("bus driven outside a read strobe");
	oe_width_a: assert property (strobe && stbQ && readNotWrite
		|-> hostDataOe == (busWidth8 ? 8'hFF : 8'hF0)) else $error("wrong lines driven");
	busy_bit_a: assert property (sr && $past(sr) && busWidth8
		|-> hostDataOut[7] == $past(busyFlag)) else $error("busy not on top line");
	write_busy_a: assert property (byteEnd && !readNotWrite && !busyFlag |=> busyFlag)
		else $error("write left busy low");
	busy_cause_a: assert property ($rose(busyFlag) |-> $past(take))
		else $error("busy rose without a strobe");
	width_hold_a: assert property (!(take && !readNotWrite && !registerSelectPin)
		|=> $stable(busWidth8)) else $error("width changed without a command");
	width_load_a: assert property (take && sr == 1'b0 && !registerSelectPin && !busyFlag
		&& busWidth8 && hostDataIn[7:5] == 3'b001 |=> busWidth8 == $past(hostDataIn[4]))
		else $error("width bit not applied");
	status_steady_a: assert property (sr && $past(sr) && $past(sr, 2) && busWidth8
		&& $past(busWidth8) && !$past(busyFlag) && !$past(busyFlag, 2)
		|-> $stable(hostDataOut)) else $error("idle status moved");
	cover property (take && !readNotWrite && !registerSelectPin);
	cover property (strobe && stbQ && sr && busyFlag);
	cover property (strobe && stbQ && readNotWrite && !busWidth8);
endmodule // lmp_port_props
bind lmp_host_port lmp_port_props u_lmp_port_props (.mclk(mclk), .rst(rst), .clkEn(clkEn),
	.oscExtSel(oscExtSel), .clockInPin(clockInPin), .registerSelectPin(registerSelectPin),
	.readNotWrite(readNotWrite), .strobe(strobe), .hostDataIn(hostDataIn),
	.hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .busyFlag(busyFlag),
	.busWidth8(busWidth8));
`default_nettype wire

// ---- lmp_host_model.sv ----
/* processor bus master model: strobed byte and nibble accesses.
   assumes a 100 ns mclk; the bench sets w4 to match the width. */
`default_nettype none
module lmp_host_model
	import lmp_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic [BYTE_W-1:0] hostDataOut,
	input  wire logic [BYTE_W-1:0] hostDataOe,
	output var logic               registerSelectPin,
	output var logic               readNotWrite,
	output var logic               strobe,
	output var logic  [BYTE_W-1:0] hostDataIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       w4 = 1'b0;       // 4-bit width in use
	logic       hostOn = 1'b0;   // host drives the lines
	logic [7:0] drv = 8'h00;     // host drive value
	logic [7:0] lastOe = 8'h00;  // enables seen at the last sample
	initial begin
		registerSelectPin = 1'b0;
		readNotWrite = 1'b1;
		strobe = 1'b0;
	end
	// open low lines
	// undriven lines show the inverse of the device value, never a stale copy
	always_comb
		for (int i = 0; i < 8; i++)
			hostDataIn[i] = hostDataOe[i] ? hostDataOut[i] :
				(hostOn && !(w4 && i < 4)) ? drv[i] : ~hostDataOut[i];
	task automatic strb(input logic rs, input logic rw, input logic [7:0] v,
		output logic [7:0] r);
		@(posedge mclk);
		#10;
		registerSelectPin = rs;
		readNotWrite = rw;
		drv = v;
		hostOn = !rw;
		strobe = 1'b1;
		@(posedge mclk);
		#50;
		r = hostDataIn;
		lastOe = hostDataOe;
		@(posedge mclk);
		#10;
		strobe = 1'b0;
		@(posedge mclk);
		#10;
		hostOn = 1'b0;
	endtask
	task automatic acc(input logic rs, input logic rw, input logic [7:0] v,
		output logic [7:0] r);
		logic [7:0] h;
		logic [7:0] l;
		if (!w4) begin
			strb(rs, rw, v, r);
		end else begin
			strb(rs, rw, v, h);
			strb(rs, rw, {v[3:0], v[7:4]}, l);
			r = {h[7:4], l[7:4]};
		end
	endtask
endmodule // lmp_host_model
`default_nettype wire

// ---- lcd_mpu_parallel_port_tb.sv ----
/* self-checking bench for the host port, driven through the bus model.
   assumes the internal divider of 40 and an external tick every second mclk cycle. */
`default_nettype none
module lcd_mpu_parallel_port_tb;
	import lmp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       oscExtSel = 1'b0;
	logic       clockInPin = 1'b0;
	logic       tickOn = 1'b0;  // external clock runs only when asked
	logic       rs, rw, stb, busy, w8;
	logic [7:0] din, dout, doe;
	int         n_fail = 0;
	int         checked = 0;
	initial forever #50 mclk = ~mclk;
	// external clock pin stands still unless a test needs ticks
	always @(posedge mclk) if (tickOn) clockInPin <= #10 ~clockInPin;
	lmp_host_port u_lmp_host_port (.mclk(mclk), .rst(rst), .clkEn(1'b1),
		.oscExtSel(oscExtSel), .clockInPin(clockInPin), .registerSelectPin(rs),
		.readNotWrite(rw), .strobe(stb), .hostDataIn(din), .hostDataOut(dout),
		.hostDataOe(doe), .busyFlag(busy), .busWidth8(w8));
	lmp_host_model u_lmp_host_model (.mclk(mclk), .hostDataOut(dout), .hostDataOe(doe),
		.registerSelectPin(rs), .readNotWrite(rw), .strobe(stb), .hostDataIn(din));
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic put(input logic sel, input logic [7:0] v);
		logic [7:0] d;
		u_lmp_host_model.acc(sel, 1'b0, v, d);
	endtask
	task automatic get(input logic sel, input logic [7:0] exp, input string what);
		logic [7:0] d;
		u_lmp_host_model.acc(sel, 1'b1, 8'h00, d);
		chk(d, exp, what);
	endtask
	// bounded wait on the busy bit of status reads
	task automatic poll();
		logic [7:0] s;
		for (int i = 0; i < 300; i++) begin
			u_lmp_host_model.acc(1'b0, 1'b1, 8'h00, s);
			if (s[7] === 1'b0)
				return;
		end
		n_fail++;
		$display("BAD %0t busy never cleared", $time);
		conclude();
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		#10 rst = 1'b0;
		chk({7'h00, w8}, 8'h01, "reset width");
		chk({7'h00, busy}, 8'h00, "reset busy");
		get(1'b0, 8'h00, "reset status");
		chk(u_lmp_host_model.lastOe, 8'hFF, "8-bit enables");
		put(1'b0, 8'h85);
		get(1'b0, 8'h85, "busy status");
		put(1'b0, 8'h8A);
		poll();
		get(1'b0, 8'h05, "dropped command");
		put(1'b1, 8'h41);
		put(1'b1, 8'h42);
		poll();
		get(1'b0, 8'h07, "step after writes");
		put(1'b0, 8'h85);
		poll();
		get(1'b1, 8'h41, "first read");
		poll();
		get(1'b1, 8'h42, "next read");
		poll();
		get(1'b0, 8'h07, "step after reads");
		put(1'b0, 8'h45);
		poll();
		put(1'b1, 8'h1F);
		poll();
		put(1'b0, 8'h85);
		poll();
		get(1'b1, 8'h41, "text kept apart");
		poll();
		put(1'b0, 8'h45);
		poll();
		get(1'b1, 8'h1F, "glyph read");
		poll();
		put(1'b0, 8'h04);
		poll();
		put(1'b0, 8'h8A);
		poll();
		put(1'b1, 8'h77);
		poll();
		get(1'b0, 8'h09, "step down");
		put(1'b0, 8'h38);
		get(1'b0, 8'h89, "command hidden");
		poll();
		put(1'b0, 8'h06);
		poll();
		oscExtSel = 1'b1;
		put(1'b0, 8'h80);
		repeat (300) @(posedge mclk);
		chk({7'h00, busy}, 8'h01, "held without ticks");
		tickOn = 1'b1;
		poll();
		tickOn = 1'b0;
		for (int i = 0; i < 17; i++)
			put(1'b1, 8'h60 + 8'(i));
		chk({7'h00, busy}, 8'h01, "queue waiting");
		tickOn = 1'b1;
		poll();
		get(1'b0, 8'h10, "queue of sixteen");
		put(1'b0, 8'h8F);
		poll();
		get(1'b1, 8'h6F, "last queued byte");
		poll();
		tickOn = 1'b0;
		oscExtSel = 1'b0;
		put(1'b0, 8'h20);
		chk({7'h00, w8}, 8'h00, "4-bit width");
		u_lmp_host_model.w4 = 1'b1;
		poll();
		chk(u_lmp_host_model.lastOe, 8'hF0, "4-bit enables");
		put(1'b0, 8'h81);
		poll();
		put(1'b1, 8'h5A);
		poll();
		put(1'b0, 8'h81);
		poll();
		get(1'b1, 8'h5A, "nibble read");
		poll();
		get(1'b0, 8'h02, "nibble status");
		conclude();
	end
endmodule // lcd_mpu_parallel_port_tb
`default_nettype wire
